// *** core/acs_pkg.sv ***
/*
 * acs_pkg: offsets, field positions, reset values and carriers for the
 * channel/setup register bank and sequencer.
 * Assumes a word-level register port from the serial front end.
 */
package acs_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [5:0] OFS_CTRL   = 6'h01;
    localparam logic [5:0] OFS_DIAGEN = 6'h07;
    localparam logic [5:0] OFS_TALLY  = 6'h08;
    localparam logic [5:0] OFS_ROUTE0 = 6'h09;
    localparam logic [5:0] OFS_ROUTEF = 6'h18;
    localparam logic [5:0] OFS_SETUP0 = 6'h19;
    localparam logic [5:0] OFS_SETUP7 = 6'h20;
    // ----------------------------------------
    // reset values and writable masks
    // ----------------------------------------
    localparam logic [15:0] CTRL_RST    = 16'h0000;
    localparam logic [15:0] CTRL_MASK   = 16'h1FFF;
    localparam logic [23:0] DIAGEN_RST  = 24'h000040;
    localparam logic [23:0] DIAGEN_MASK = 24'h7FFFFF;
    localparam logic [23:0] FLAG_MASK   = 24'h0FFAFF;
    localparam logic [7:0]  TALLY_RST   = 8'h00;
    localparam logic [15:0] ROUTE0_RST  = 16'h8001;
    localparam logic [15:0] ROUTE_RST   = 16'h0001;
    localparam logic [15:0] ROUTE_MASK  = 16'hF3FF;
    localparam logic [15:0] SETUP_RST   = 16'h0860;
    localparam logic [15:0] SETUP_MASK  = 16'h0FFF;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int RT_EN    = 15;
    localparam int RT_SET   = 12;
    localparam int RT_POS   = 5;
    localparam int RT_NEG   = 0;
    localparam int ST_BIP   = 11;
    localparam int ST_BUFP  = 6;
    localparam int ST_BUFM  = 5;
    localparam int ST_GAIN  = 0;
    localparam int CT_MODE  = 2;
    localparam int DE_TALLY = 22;
    localparam logic [3:0] MODE_CONT = 4'h0;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [23:0] wdata;
    } acs_req_t;

    typedef struct packed {
        logic        wr;
        logic        is_gain;
        logic [2:0]  setup;
        logic [23:0] coef;
    } acs_cal_t;
endpackage

// *** core/acs_core.sv ***
/*
 * acs_core: control, diagnostic enable, clock tally, sixteen input routes,
 * eight setups, ascending channel sequencer and calibration write-back.
 * Assumes the serial front end presents one word access per cycle and the
 * modulator reports conversion and calibration completion as pulses.
 */
// Function
// (R1) sixteen route registers: enable, setup, pos, neg
// (R2) route top bit includes pairing in conversion
// (R3) sequencer ascends enabled routes, wraps to lowest
// (R4) each route picks one of eight setups
// (R5) calibration coefficient written to route's setup
// (R6) five-bit positive and negative input selects
// (R7) unity gain: buffers follow separate bits
// (R8) gain above one forces both buffers on
// (R9) unity gain powers down, bypasses amplifier
// (R10) eight setup registers, reset 0x0860
// (R11) diagnostic enable register, reset 0x000040
// (R12) read-only clock tally, reset zero
// (R13) sixteen-bit control register, reset zero
// (R14) enabled flags OR into summary error
// (R15) tally counts master clock pulses
// (R16) bipolar selects offset binary, else straight
// (R17) route zero resets to 0x8001
// (R18) skip disabled routes, repeat single one
`timescale 1ns/1ps
module acs_core
    import acs_pkg::*;
#(
    parameter int NROUTE = 16,
    parameter int NSETUP = 8
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire acs_req_t    req,
    input  wire logic        conv_done,
    input  wire logic        cal_done,
    input  wire logic        cal_is_gain,
    input  wire logic [23:0] cal_coef,
    input  wire logic [23:0] diag_flags,
    output logic [23:0]      rdata_q,
    output logic             rvalid_q,
    output logic [3:0]       route_q,
    output logic [4:0]       positive_input_select_q,
    output logic [4:0]       negative_input_select_q,
    output logic [2:0]       setup_q,
    output logic [2:0]       gain_select_q,
    output logic             positive_buffer_on_q,
    output logic             negative_buffer_on_q,
    output logic             amp_on_q,
    output logic             offset_binary_q,
    output logic             err_q,
    output acs_cal_t         cal_q
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [15:0] ctrl_q;
    logic [23:0] diagen_q;
    logic [7:0]  tally_q;
    logic [15:0] rt_q [NROUTE];
    logic [15:0] st_q [NSETUP];
    logic        wr_rt;
    logic        wr_st;
    logic [3:0]  rt_idx;
    logic [2:0]  st_idx;
    logic [15:0] cur_rt;
    logic [15:0] cur_st;
    logic [2:0]  gain;
    logic        converting;
    logic [NROUTE-1:0] en_vec;

    assign rt_idx = 4'(req.addr - OFS_ROUTE0);
    assign st_idx = 3'(req.addr - OFS_SETUP0);
    assign wr_rt  = req.wr && req.addr >= OFS_ROUTE0 && req.addr <= OFS_ROUTEF;
    assign wr_st  = req.wr && req.addr >= OFS_SETUP0 && req.addr <= OFS_SETUP7;
    assign cur_rt = rt_q[route_q];
    assign cur_st = st_q[cur_rt[RT_SET+:3]];                       // see (R4)
    assign gain   = cur_st[ST_GAIN+:3];
    assign converting = ctrl_q[CT_MODE+:4] == MODE_CONT;

    always_comb begin
        for (int i = 0; i < NROUTE; i++) begin
            en_vec[i] = rt_q[i][RT_EN];                            // see (R2)
        end
    end

    // next enabled route above cur, wrapping; holds if none enabled
    function automatic logic [3:0] next_route(input logic [NROUTE-1:0] en, input logic [3:0] cur);
        logic [3:0] n;
        logic [3:0] res;
        logic       hit;
        res = cur;
        hit = 1'b0;
        for (int k = 1; k <= NROUTE; k++) begin
            n = 4'(cur + 4'(k));
            if (!hit && en[n]) begin
                res = n;
                hit = 1'b1;
            end
        end
        return res;
    endfunction

    // ----------------------------------------
    // control and diagnostic enable
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;                                    // see (R13)
        end else if (req.wr && req.addr == OFS_CTRL) begin
            ctrl_q <= req.wdata[15:0] & CTRL_MASK;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            diagen_q <= DIAGEN_RST;                                // see (R11)
        end else if (req.wr && req.addr == OFS_DIAGEN) begin
            diagen_q <= req.wdata & DIAGEN_MASK;
        end
    end

    // ----------------------------------------
    // clock tally: host writes ignored
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tally_q <= TALLY_RST;                                  // see (R12)
        end else if (diagen_q[DE_TALLY]) begin
            tally_q <= tally_q + 8'h01;                            // see (R15)
        end
    end

    // ----------------------------------------
    // route and setup banks
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NROUTE; i++) begin
                rt_q[i] <= (i == 0) ? ROUTE0_RST : ROUTE_RST;      // see (R17)
            end
        end else if (wr_rt) begin
            rt_q[rt_idx] <= req.wdata[15:0] & ROUTE_MASK;          // see (R1)
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NSETUP; i++) begin
                st_q[i] <= SETUP_RST;                              // see (R10)
            end
        end else if (wr_st) begin
            st_q[st_idx] <= req.wdata[15:0] & SETUP_MASK;
        end
    end

    // ----------------------------------------
    // read port: unmapped offsets read zero
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q  <= 24'h000000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= req.rd;
            if (req.rd) begin
                if (req.addr == OFS_CTRL) begin
                    rdata_q <= {8'h00, ctrl_q};
                end else if (req.addr == OFS_DIAGEN) begin
                    rdata_q <= diagen_q;
                end else if (req.addr == OFS_TALLY) begin
                    rdata_q <= {16'h0000, tally_q};
                end else if (req.addr >= OFS_ROUTE0 && req.addr <= OFS_ROUTEF) begin
                    rdata_q <= {8'h00, rt_q[rt_idx]};
                end else if (req.addr >= OFS_SETUP0 && req.addr <= OFS_SETUP7) begin
                    rdata_q <= {8'h00, st_q[st_idx]};
                end else begin
                    rdata_q <= 24'h000000;
                end
            end
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            route_q <= 4'h0;
        end else if (converting && conv_done) begin
            route_q <= next_route(en_vec, route_q);                // see (R3) (R18)
        end
    end

    // ----------------------------------------
    // front-end steering, registered
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            positive_input_select_q <= 5'h00;
            negative_input_select_q <= 5'h00;
            setup_q                 <= 3'h0;
            gain_select_q           <= 3'h0;
            positive_buffer_on_q    <= 1'b0;
            negative_buffer_on_q    <= 1'b0;
            amp_on_q                <= 1'b0;
            offset_binary_q         <= 1'b0;
        end else begin
            positive_input_select_q <= cur_rt[RT_POS+:5];          // see (R6)
            negative_input_select_q <= cur_rt[RT_NEG+:5];
            setup_q                 <= cur_rt[RT_SET+:3];
            gain_select_q           <= gain;
            positive_buffer_on_q    <= (gain != 3'h0) || cur_st[ST_BUFP]; // see (R7) (R8)
            negative_buffer_on_q    <= (gain != 3'h0) || cur_st[ST_BUFM]; // see (R7) (R8)
            amp_on_q                <= gain != 3'h0;               // see (R9)
            offset_binary_q         <= cur_st[ST_BIP];             // see (R16)
        end
    end

    // ----------------------------------------
    // error summary and calibration write-back
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            err_q <= 1'b0;
        end else begin
            err_q <= |(diag_flags & diagen_q & FLAG_MASK);         // see (R14)
        end
    end

    // coefficient lands in the setup of the route being converted
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cal_q <= '0;
        end else begin
            cal_q.wr      <= cal_done;                             // see (R5)
            cal_q.is_gain <= cal_is_gain;
            cal_q.setup   <= cur_rt[RT_SET+:3];
            cal_q.coef    <= cal_coef;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    route_skip_a: assert property (conv_done && converting && en_vec != '0 |=> en_vec[route_q]) // see (R3)
        else $error("sequencer landed on disabled route");
    route_single_a: assert property (conv_done && converting && $onehot(en_vec) && en_vec[route_q]
        |=> $stable(route_q)) // see (R18)
        else $error("single route not repeated");
    route_hold_a: assert property (!converting |=> $stable(route_q)) // see (R3)
        else $error("route moved while idle");
    buf_force_a: assert property (gain != 3'h0 |=> positive_buffer_on_q && negative_buffer_on_q) // see (R8)
        else $error("buffers not forced on");
    amp_bypass_a: assert property (gain == 3'h0 |=> !amp_on_q) // see (R9)
        else $error("amplifier on at unity gain");
    tally_ro_a: assert property (req.wr && req.addr == OFS_TALLY && !diagen_q[DE_TALLY]
        |=> $stable(tally_q)) // see (R12)
        else $error("tally changed by write");
    tally_step_a: assert property (diagen_q[DE_TALLY] |=> tally_q == $past(tally_q) + 8'h01) // see (R15)
        else $error("tally missed a clock");
    err_sum_a: assert property ((diag_flags & diagen_q & FLAG_MASK) != '0 |=> err_q) // see (R14)
        else $error("summary error missed");
    cal_dest_a: assert property (cal_done |=> cal_q.wr && cal_q.setup == $past(cur_rt[RT_SET+:3])) // see (R5)
        else $error("calibration to wrong setup");
    read_ack_a: assert property (req.rd |=> rvalid_q ##1 !rvalid_q || $past(req.rd)) // see (R1)
        else $error("read not answered");

    wrap_c: cover property (conv_done && converting && route_q == 4'hF ##1 route_q != 4'hF);
    gain_c: cover property (gain != 3'h0 && !cur_st[ST_BUFP]);
    cal_c:  cover property (cal_done && cal_is_gain);
endmodule

// *** tb/acs_host.sv ***
/*
 * acs_host: host-side model of the word register port, with write and
 * read tasks.
 * Assumes acs_core answers a read at the edge that takes it.
 */
`timescale 1ns/1ps
module acs_host
    import acs_pkg::*;
(
    input  wire logic        mclk,
    output acs_req_t         req,
    input  wire logic [23:0] rdata_q,
    input  wire logic        rvalid_q
);
    initial req = '0;

    // idle data is inverted so that a stale word never passes for a live one
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        @(posedge mclk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        req.wr    <= 1'b0;
        req.wdata <= ~d;
    endtask

    task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic ok);
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1;
        ok = rvalid_q;
        d  = rdata_q;
    endtask
endmodule

// *** tb/acs_core_tb.sv ***
/*
 * acs_core_tb: random and corner tests of the register bank, sequencer,
 * calibration strobe, summary error and clock tally.
 * Assumes acs_host drives the register port.
 */
`timescale 1ns/1ps
module acs_core_tb;
    import acs_pkg::*;
    logic        mclk, rst_n, conv_done, cal_done, cal_is_gain;
    logic [23:0] cal_coef, diag_flags, rdata_q, d0, d1;
    logic        rvalid_q, amp_on_q, offset_binary_q, err_q, ok;
    logic        positive_buffer_on_q, negative_buffer_on_q;
    logic [4:0]  positive_input_select_q, negative_input_select_q;
    logic [3:0]  route_q, cur;
    logic [2:0]  setup_q, gain_select_q;
    logic [15:0] rt [16];
    logic [15:0] st [8];
    logic [31:0] v, w;
    acs_req_t    req;
    acs_cal_t    cal_q;
    int          seed, err_count, checked;

    acs_core dut (.mclk, .rst_n, .req, .conv_done, .cal_done, .cal_is_gain, .cal_coef, .diag_flags,
        .rdata_q, .rvalid_q, .route_q, .positive_input_select_q, .negative_input_select_q, .setup_q,
        .gain_select_q, .positive_buffer_on_q, .negative_buffer_on_q, .amp_on_q, .offset_binary_q,
        .err_q, .cal_q);
    acs_host host (.mclk, .req, .rdata_q, .rvalid_q);

    always #12.5 mclk = ~mclk;

    // ------------
    // helpers
    // ------------
    function automatic logic [3:0] nxt(input logic [3:0] c);
        for (int i = 1; i <= 16; i++)
            if (rt[4'(c + i)][15]) return 4'(c + i);
        return c;
    endfunction

    function automatic logic [23:0] msk(input logic [5:0] a);
        if (a == 6'h01) return 24'h001FFF;
        if (a == 6'h07) return 24'h7FFFFF;
        if (a >= 6'h09 && a <= 6'h18) return 24'h00F3FF;
        if (a >= 6'h19 && a <= 6'h20) return 24'h000FFF;
        return 24'h000000;
    endfunction

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [23:0] e);
        logic [23:0] d;
        logic        k;
        host.rd(a, d, k);
        chk({k, d}, {1'b1, e});
    endtask

    // route index moves at the taken edge, steering one edge later
    task automatic step(input logic go);
        logic [15:0] r;
        logic [15:0] s;
        logic        g;
        @(posedge mclk);
        conv_done <= 1'b1;
        @(posedge mclk);
        conv_done <= 1'b0;
        if (go) cur = nxt(cur);
        @(posedge mclk);
        #1;
        r = rt[cur];
        s = st[r[14:12]];
        g = |s[2:0];
        chk(route_q, cur);
        chk({positive_input_select_q, negative_input_select_q, setup_q, gain_select_q},
            {r[9:5], r[4:0], r[14:12], s[2:0]});
        chk({positive_buffer_on_q, negative_buffer_on_q, amp_on_q, offset_binary_q},
            {g | s[6], g | s[5], g, s[11]});
    endtask

    task automatic set_en(input logic [15:0] m);
        for (int i = 0; i < 16; i++) begin
            rt[i][15] = m[i];
            host.wr(6'(9 + i), {8'h00, rt[i]});
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------------
    // tests
    // ------------
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        {mclk, rst_n, conv_done, cal_done, cal_is_gain, cal_coef, diag_flags} = '0;
        seed = 32'hCDFC;
        cur = 4'h0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rd_chk(6'h01, 24'h000000);
        rd_chk(6'h07, 24'h000040);
        rd_chk(6'h08, 24'h000000);
        rd_chk(6'h09, 24'h008001);
        for (int i = 0; i < 8; i++) rd_chk(6'(25 + i), 24'h000860);
        $display("test reset values done");
        // tally kept off here so that the ignored write to it reads back zero
        for (int a = 1; a <= 33; a++) begin
            v = $random(seed);
            if (a == 7) v[22] = 1'b0;
            host.wr(6'(a), v[23:0]);
            rd_chk(6'(a), v[23:0] & msk(6'(a)));
            if (a >= 9 && a <= 24) rt[a - 9] = v[15:0] & 16'hF3FF;
            if (a >= 25 && a <= 32) st[a - 25] = v[15:0] & 16'h0FFF;
        end
        $display("test register access done");
        host.wr(6'h01, 24'h000000);
        repeat (12) step(1'b1);
        host.wr(6'h01, 24'h000004);
        repeat (2) step(1'b0);
        host.wr(6'h01, 24'h000000);
        set_en(16'h8004);
        repeat (4) step(1'b1);
        set_en(16'h0080);
        repeat (2) step(1'b1);
        $display("test sequencer done");
        for (int i = 0; i < 6; i++) begin
            v = $random(seed);
            set_en(v[15:0]);
            step(1'b1);
            @(posedge mclk);
            cal_done <= 1'b1;
            cal_is_gain <= v[31];
            cal_coef <= v[23:0];
            @(posedge mclk);
            cal_done <= 1'b0;
            #1 chk({cal_q.wr, cal_q.is_gain, cal_q.setup, cal_q.coef}, {1'b1, v[31], rt[cur][14:12], v[23:0]});
            @(posedge mclk);
            #1 chk(cal_q.wr, 1'b0);
        end
        $display("test calibration done");
        for (int i = 0; i < 16; i++) begin
            v = $random(seed);
            w = $random(seed);
            if (i < 4) w = 32'h1 << i;
            host.wr(6'h07, w[23:0]);
            diag_flags <= v[23:0];
            repeat (2) @(posedge mclk);
            #1 chk(err_q, |(v[23:0] & w[22:0] & 24'h0FFAFF));
        end
        $display("test summary error done");
        host.wr(6'h07, 24'h400040);
        host.rd(6'h08, d0, ok);
        repeat (300) @(posedge mclk);
        host.wr(6'h08, 24'h0000AA);
        host.rd(6'h08, d1, ok);
        chk(8'(d1 - d0), 8'h30);
        host.wr(6'h07, 24'h000040);
        host.rd(6'h08, d0, ok);
        host.rd(6'h08, d1, ok);
        chk(d1 - d0, 24'h000000);
        $display("test clock tally done");
        report_and_stop();
    end
endmodule
